/* rtl/shadow_stack_return_guard.sv */
// shadow stack return guard: pushes and checks return info, switches stacks on privilege change
// assumes pipeline and memory unit run on core_clk; the guard holds a memory request until memAck
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module shadow_stack_return_guard (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [ssg_pkg::REG_AW-1:0] regAddr,
	input wire logic [ssg_pkg::DATA_W-1:0] regWdata,
	input wire logic regWe,
	input wire logic regRe,
	output logic [ssg_pkg::DATA_W-1:0] regRdata,
	input wire logic mgmtAccess,
	input wire logic flowEnable,
	input wire logic protectedModeEnable,
	input wire logic pagingEnable,
	input wire logic virtual8086Flag,
	input wire logic longModeActive,
	input wire logic codeLong64,
	input wire logic [1:0] currentPrivilegeLevel,
	input wire logic opValid,
	input wire ssg_pkg::ssg_op_e opKind,
	input wire logic [1:0] opTargetLevel,
	input wire logic [ssg_pkg::DATA_W-1:0] opLinearReturn,
	input wire logic [ssg_pkg::DATA_W-1:0] opCodeSelector,
	input wire logic opZeroDisp,
	input wire logic [2:0] opStackIndex,
	input wire logic [15:0] opParmBytes,
	output logic opReady,
	output logic opDone,
	output logic returnCommit,
	output logic controlProtectionFault,
	output logic generalProtectionFault,
	output logic [16:0] progSpAdjust,
	input wire logic pageWriteReq,
	input wire logic pageShadowAttr,
	input wire logic writeFromTransfer,
	input wire logic writeFromMgmt,
	output logic writeRefused,
	input wire logic operandNamesShadowPtr,
	output logic operandRefused,
	output logic memReq,
	output logic memWrite,
	output logic memLock,
	output logic [ssg_pkg::DATA_W-1:0] memAddr,
	output logic [ssg_pkg::DATA_W-1:0] memWdata,
	input wire logic memAck,
	input wire logic [ssg_pkg::DATA_W-1:0] memRdata,
	output logic shadowActive,
	output logic [ssg_pkg::DATA_W-1:0] shadowTopPointer
);
	import ssg_pkg::*;

	ssg_state_e state;
	ssg_op_e kind;
	logic [1:0] fromLvl;
	logic [1:0] cnt;
	logic [1:0] idx;
	logic [DATA_W-1:0] linear_return_address;
	logic [DATA_W-1:0] csv;
	logic [DATA_W-1:0] oldPtr;
	logic [DATA_W-1:0] newPtr;
	logic [DATA_W-1:0] shadow_top_pointer;
	logic [DATA_W-1:0] isstBase;
	logic [DATA_W-1:0] pushBuf [PUSH_MAX];
	logic [DATA_W-1:0] popBuf [PUSH_MAX];
	logic [DATA_W-1:0] plPtr [LEVELS];
	logic userEn;
	logic supEn;
	logic statCp;
	logic statGp;
	logic chkCs;
	logic restorePtr;
	logic featureOn;
	logic curEn;
	logic tgtEn;
	logic raise;
	logic mismatch;
	logic tokStart;
	logic tokDone;
	logic tokOk;
	logic [DATA_W-1:0] busyToken;
	logic ptrWrite;
	logic useTable;

	function automatic logic [DATA_W-1:0] widthFix(input logic [DATA_W-1:0] v, input logic wide);
		widthFix = wide ? v : (v & LEGACY_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// enables and combinational guards

	assign featureOn = flowEnable && protectedModeEnable && pagingEnable
		&& !virtual8086Flag;
	assign curEn = featureOn && ((currentPrivilegeLevel == LVL_USER) ? userEn : supEn);
	assign tgtEn = featureOn && ((opTargetLevel == LVL_USER) ? userEn : supEn);
	assign raise = opTargetLevel < currentPrivilegeLevel;
	assign useTable = (opKind == OP_INTR) && longModeActive && (opStackIndex != IST_NONE);
	assign shadowActive = curEn;
	assign opReady = (state == ST_IDLE);
	assign memReq = (state == ST_INTERRUPT_SHADOW_POINTER_TABLE) || (state == ST_TOKRD) || (state == ST_TOKWR)
		|| (state == ST_PUSH) || (state == ST_POP);
	assign shadowTopPointer = shadow_top_pointer;
	assign writeRefused = pageWriteReq && pageShadowAttr && !writeFromTransfer && !writeFromMgmt;
	// pointer is never a general operand
	assign operandRefused = operandNamesShadowPtr;
	assign ptrWrite = regWe && (regAddr == REG_PTR) && mgmtAccess;
	assign tokStart = (state == ST_TOKRD) && memAck;
	assign mismatch = (kind == OP_NEAR_RET) ? (popBuf[0] != linear_return_address)
		: ((popBuf[1] != linear_return_address) || (chkCs && (popBuf[0] != csv)));

	ssg_token_check u_tok (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.start(tokStart),
		.token(memRdata),
		.incoming(newPtr),
		.done(tokDone),
		.ok(tokOk),
		.busyToken(busyToken)
	);

	////////////////////////////////////////////////////////////////////////
	// configuration registers and sticky fault causes

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			userEn <= 1'b0;
			supEn <= 1'b0;
			isstBase <= ZERO_WORD;
		end else if (ce && regWe) begin
			if (regAddr == REG_UCFG) begin
				userEn <= regWdata[CFG_EN_BIT];
			end else if (regAddr == REG_SCFG) begin
				supEn <= regWdata[CFG_EN_BIT];
			end else if (regAddr == REG_INTERRUPT_SHADOW_POINTER_TABLE) begin
				isstBase <= regWdata;
			end
		end
	end

	// set wins over a write-one clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			statCp <= 1'b0;
			statGp <= 1'b0;
		end else if (ce) begin
			statCp <= controlProtectionFault || (statCp && !(regWe && regAddr == REG_STAT && regWdata[STAT_CP_BIT]));
			statGp <= generalProtectionFault || (statGp && !(regWe && regAddr == REG_STAT && regWdata[STAT_GP_BIT]));
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= ZERO_WORD;
		end else if (ce && regRe) begin
			regRdata <= ZERO_WORD;
			if (regAddr == REG_CAP) begin
				regRdata[CAP_SS_BIT] <= 1'b1;
			end else if (regAddr == REG_UCFG) begin
				regRdata[CFG_EN_BIT] <= userEn;
			end else if (regAddr == REG_SCFG) begin
				regRdata[CFG_EN_BIT] <= supEn;
			end else if (regAddr >= REG_PL0 && regAddr <= REG_PL3) begin
				regRdata <= plPtr[2'(regAddr - REG_PL0)];
			end else if (regAddr == REG_INTERRUPT_SHADOW_POINTER_TABLE) begin
				regRdata <= isstBase;
			end else if (regAddr == REG_PTR && mgmtAccess) begin
				regRdata <= shadow_top_pointer;
			end else if (regAddr == REG_STAT) begin
				regRdata[STAT_CP_BIT] <= statCp;
				regRdata[STAT_GP_BIT] <= statGp;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer sequencer, owns the pointers and the memory request

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			kind <= OP_NONE;
			fromLvl <= LVL_USER;
			cnt <= IDX_ZERO;
			idx <= IDX_ZERO;
			linear_return_address <= ZERO_WORD;
			csv <= ZERO_WORD;
			oldPtr <= ZERO_WORD;
			newPtr <= ZERO_WORD;
			shadow_top_pointer <= ZERO_WORD;
			chkCs <= 1'b0;
			restorePtr <= 1'b0;
			memWrite <= 1'b0;
			memLock <= 1'b0;
			memAddr <= ZERO_WORD;
			memWdata <= ZERO_WORD;
			opDone <= 1'b0;
			returnCommit <= 1'b0;
			controlProtectionFault <= 1'b0;
			generalProtectionFault <= 1'b0;
			progSpAdjust <= 17'h0;
			for (int i = 0; i < PUSH_MAX; i++) begin
				pushBuf[i] <= ZERO_WORD;
				popBuf[i] <= ZERO_WORD;
			end
			for (int i = 0; i < LEVELS; i++) begin
				plPtr[i] <= ZERO_WORD;
			end
		end else if (ce) begin
			opDone <= 1'b0;
			returnCommit <= 1'b0;
			controlProtectionFault <= 1'b0;
			generalProtectionFault <= 1'b0;
			if (regWe && regAddr >= REG_PL0 && regAddr <= REG_PL3) begin
				plPtr[2'(regAddr - REG_PL0)] <= regWdata;
			end
			if (ptrWrite) begin
				shadow_top_pointer <= widthFix(regWdata, codeLong64);
			end
			case (state)
				ST_IDLE: begin
					if (opValid) begin
						kind <= opKind;
						fromLvl <= currentPrivilegeLevel;
						linear_return_address <= opLinearReturn;
						csv <= opCodeSelector;
						oldPtr <= shadow_top_pointer;
						idx <= IDX_ZERO;
						// program stack moves one word plus opParmBytes
						progSpAdjust <= 17'(WORD_BYTES) + 17'(opParmBytes);
						pushBuf[0] <= opCodeSelector;
						pushBuf[1] <= opLinearReturn;
						pushBuf[2] <= shadow_top_pointer;
						memAddr <= shadow_top_pointer;
						memWrite <= 1'b0;
						memLock <= 1'b0;
						state <= ST_DONE;
						case (opKind)
							OP_NEAR_CALL: begin
								if (curEn && !opZeroDisp) begin
									pushBuf[0] <= opLinearReturn;
									cnt <= CNT_ONE;
									memAddr <= widthFix(shadow_top_pointer - WORD_BYTES, codeLong64);
									memWdata <= opLinearReturn;
									memWrite <= 1'b1;
									state <= ST_PUSH;
								end
							end
							OP_NEAR_RET: begin
								returnCommit <= !curEn;
								if (curEn) begin
									cnt <= CNT_ONE;
									state <= ST_POP;
								end
							end
							OP_FAR_CALL, OP_INTR: begin
								if (opTargetLevel == currentPrivilegeLevel) begin
									if (curEn) begin
										cnt <= CNT_TWO;
										memAddr <= widthFix(shadow_top_pointer - WORD_BYTES, codeLong64);
										memWdata <= opCodeSelector;
										memWrite <= 1'b1;
										state <= ST_PUSH;
									end
								end else if (raise) begin
									if (currentPrivilegeLevel == LVL_USER && curEn) begin
										plPtr[LVL_USER] <= shadow_top_pointer;
									end
									cnt <= CNT_THREE;
									if (tgtEn && useTable) begin
										memAddr <= isstBase + (64'(opStackIndex) << IDX_SHIFT);
										state <= ST_INTERRUPT_SHADOW_POINTER_TABLE;
									end else if (tgtEn) begin
										newPtr <= plPtr[opTargetLevel];
										state <= ST_ALIGN;
									end
								end
							end
							OP_FAR_RET: begin
								returnCommit <= 1'b1;
								if (opTargetLevel == currentPrivilegeLevel && curEn) begin
									returnCommit <= 1'b0;
									cnt <= CNT_TWO;
									chkCs <= 1'b0;
									restorePtr <= 1'b0;
									state <= ST_POP;
								end else if (opTargetLevel == LVL_USER && !raise) begin
									if (tgtEn) begin
										shadow_top_pointer <= widthFix(plPtr[LVL_USER], codeLong64);
									end
								end else if (!raise && opTargetLevel != currentPrivilegeLevel && curEn) begin
									returnCommit <= 1'b0;
									cnt <= CNT_THREE;
									chkCs <= 1'b1;
									restorePtr <= 1'b1;
									state <= ST_POP;
								end
							end
							default: begin
								state <= ST_DONE;
							end
						endcase
					end
				end
				ST_INTERRUPT_SHADOW_POINTER_TABLE: begin
					if (memAck) begin
						newPtr <= memRdata;
						state <= ST_ALIGN;
					end
				end
				ST_ALIGN: begin
					if ((newPtr & ALIGN_MASK) != ZERO_WORD) begin
						generalProtectionFault <= 1'b1;
						state <= ST_DONE;
					end else begin
						memAddr <= newPtr;
						memWrite <= 1'b0;
						memLock <= 1'b1;
						state <= ST_TOKRD;
					end
				end
				ST_TOKRD: begin
					if (memAck) begin
						state <= ST_TOKCHK;
					end
				end
				ST_TOKCHK: begin
					if (tokDone && tokOk) begin
						memWrite <= 1'b1;
						memWdata <= busyToken;
						state <= ST_TOKWR;
					end else if (tokDone) begin
						memLock <= 1'b0;
						generalProtectionFault <= 1'b1;
						state <= ST_DONE;
					end
				end
				ST_TOKWR: begin
					if (memAck) begin
						memLock <= 1'b0;
						shadow_top_pointer <= newPtr;
						state <= ST_DONE;
						if (fromLvl != LVL_USER) begin
							memAddr <= widthFix(newPtr - WORD_BYTES, codeLong64);
							memWdata <= pushBuf[0];
							state <= ST_PUSH;
						end
					end
				end
				ST_PUSH: begin
					if (memAck) begin
						shadow_top_pointer <= widthFix(shadow_top_pointer - WORD_BYTES, codeLong64);
						if (idx == cnt - IDX_STEP) begin
							memWrite <= 1'b0;
							state <= ST_DONE;
						end else begin
							idx <= idx + IDX_STEP;
							memAddr <= widthFix(memAddr - WORD_BYTES, codeLong64);
							memWdata <= pushBuf[idx + IDX_STEP];
						end
					end
				end
				ST_POP: begin
					if (memAck) begin
						popBuf[cnt - IDX_STEP - idx] <= memRdata;
						shadow_top_pointer <= widthFix(shadow_top_pointer + WORD_BYTES, codeLong64);
						memAddr <= widthFix(memAddr + WORD_BYTES, codeLong64);
						idx <= idx + IDX_STEP;
						if (idx == cnt - IDX_STEP) begin
							state <= ST_CHECK;
						end
					end
				end
				ST_CHECK: begin
					if (mismatch) begin
						controlProtectionFault <= 1'b1;
						shadow_top_pointer <= oldPtr;
					end else begin
						returnCommit <= 1'b1;
						if (restorePtr) begin
							shadow_top_pointer <= widthFix(popBuf[2], codeLong64);
						end
					end
					state <= ST_DONE;
				end
				ST_DONE: begin
					opDone <= 1'b1;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_near_call;
		ce && state == ST_IDLE && opValid && opKind == OP_NEAR_CALL && curEn;
	endsequence
	sequence s_tok_pass;
		ce && state == ST_TOKCHK && tokDone && tokOk;
	endsequence

	a_cap_flag: assert property (ce && regRe && regAddr == REG_CAP |=> regRdata[CAP_SS_BIT])
		else $error("support flag not reported");
	a_global_gate: assert property (!(flowEnable && protectedModeEnable && pagingEnable) |-> !shadowActive)
		else $error("shadow stack active without global enable");
	a_v86_off: assert property (virtual8086Flag |-> !shadowActive)
		else $error("shadow stack active in virtual-8086 mode");
	a_level_gate: assert property (shadowActive && currentPrivilegeLevel == LVL_USER |-> userEn)
		else $error("user shadow stack active while disabled");
	a_ptr_width: assert property (ce && ptrWrite && !codeLong64 |=> shadow_top_pointer[DATA_W-1:32] == 32'h0)
		else $error("legacy pointer wider than 32 bits");
	a_ptr_guard: assert property (ce && regWe && regAddr == REG_PTR && !mgmtAccess && state == ST_IDLE && !opValid |=> $stable(shadow_top_pointer))
		else $error("pointer changed by ordinary write");
	a_page_refuse: assert property (pageWriteReq && pageShadowAttr && !writeFromTransfer && !writeFromMgmt |-> writeRefused)
		else $error("ordinary write to shadow page not refused");
	a_call_push: assert property ((s_near_call and !opZeroDisp) |=> state == ST_PUSH && memWrite && memWdata == $past(opLinearReturn))
		else $error("near call did not push return address");
	a_zero_skip: assert property ((s_near_call and opZeroDisp) |=> state == ST_DONE && !memReq)
		else $error("zero displacement call pushed");
	a_table_pick: assert property (ce && state == ST_IDLE && opValid && raise && tgtEn && useTable |=> state == ST_INTERRUPT_SHADOW_POINTER_TABLE)
		else $error("interrupt table not used");
	a_align_fault: assert property (ce && state == ST_ALIGN && newPtr[2:0] != 3'h0 |=> generalProtectionFault && state == ST_DONE)
		else $error("misaligned pointer accepted");
	a_token_busy: assert property (s_tok_pass |=> memWrite && memLock && state == ST_TOKWR)
		else $error("token busy bit not written under lock");
	a_fault_hold: assert property (controlProtectionFault |-> !returnCommit && shadow_top_pointer == oldPtr ##1 opDone)
		else $error("return committed despite mismatch");
endmodule
`default_nettype wire

/* rtl/ssg_pkg.sv */
// constants, register map and encodings of the shadow stack return guard
// assumes one core clock domain and a 64-bit data path
package ssg_pkg;
	localparam int DATA_W = 64;
	localparam int REG_AW = 4;
	localparam logic [3:0] REG_CAP = 4'h0;
	localparam logic [3:0] REG_UCFG = 4'h1;
	localparam logic [3:0] REG_SCFG = 4'h2;
	localparam logic [3:0] REG_PL0 = 4'h3;
	localparam logic [3:0] REG_PL3 = 4'h6;
	localparam logic [3:0] REG_INTERRUPT_SHADOW_POINTER_TABLE = 4'h7;
	localparam logic [3:0] REG_PTR = 4'h8;
	localparam logic [3:0] REG_STAT = 4'h9;
	localparam int CAP_SS_BIT = 7;
	localparam int CFG_EN_BIT = 0;
	localparam int STAT_CP_BIT = 0;
	localparam int STAT_GP_BIT = 1;
	localparam logic [63:0] WORD_BYTES = 64'h8;
	localparam logic [63:0] ALIGN_MASK = 64'h7;
	localparam logic [63:0] TOK_BUSY = 64'h1;
	localparam logic [63:0] TOK_RSVD = 64'h6;
	localparam logic [63:0] TOK_ADDR = 64'hFFFF_FFFF_FFFF_FFF8;
	localparam logic [63:0] LEGACY_MASK = 64'h0000_0000_FFFF_FFFF;
	localparam logic [63:0] ZERO_WORD = 64'h0;
	localparam int IDX_SHIFT = 3;
	localparam int PUSH_MAX = 3;
	localparam int LEVELS = 4;
	localparam logic [1:0] LVL_USER = 2'h3;
	localparam logic [2:0] IST_NONE = 3'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;
	localparam logic [1:0] CNT_THREE = 2'h3;
	localparam logic [1:0] IDX_ZERO = 2'h0;
	localparam logic [1:0] IDX_STEP = 2'h1;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_NEAR_CALL = 3'b001,
		OP_NEAR_RET = 3'b010,
		OP_FAR_CALL = 3'b011,
		OP_FAR_RET = 3'b100,
		OP_INTR = 3'b101
	} ssg_op_e;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_INTERRUPT_SHADOW_POINTER_TABLE = 4'b0001,
		ST_ALIGN = 4'b0010,
		ST_TOKRD = 4'b0011,
		ST_TOKCHK = 4'b0100,
		ST_TOKWR = 4'b0101,
		ST_PUSH = 4'b0110,
		ST_POP = 4'b0111,
		ST_CHECK = 4'b1000,
		ST_DONE = 4'b1001
	} ssg_state_e;
endpackage

/* rtl/ssg_token_check.sv */
// supervisor token validator: one cycle from fetched token to verdict
// assumes the caller holds the incoming pointer stable while it checks
`timescale 1ns/1ps
`default_nettype none
module ssg_token_check (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic start,
	input wire logic [ssg_pkg::DATA_W-1:0] token,
	input wire logic [ssg_pkg::DATA_W-1:0] incoming,
	output logic done,
	output logic ok,
	output logic [ssg_pkg::DATA_W-1:0] busyToken
);
	import ssg_pkg::*;

	logic fieldsClear;
	logic addrMatch;

	assign fieldsClear = (token & (TOK_RSVD | TOK_BUSY)) == ZERO_WORD;
	assign addrMatch = (token & TOK_ADDR) == (incoming & TOK_ADDR);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done <= 1'b0;
			ok <= 1'b0;
			busyToken <= ZERO_WORD;
		end else if (ce) begin
			done <= start;
			if (start) begin
				ok <= fieldsClear && addrMatch;
				busyToken <= token | TOK_BUSY;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_token_busy_reject: assert property (ce && start && (token & TOK_BUSY) != ZERO_WORD |=> done && !ok)
		else $error("busy token accepted");
	a_token_addr_reject: assert property (ce && start && !addrMatch |=> !ok)
		else $error("token with wrong address accepted");
endmodule
`default_nettype wire

/* verif/ssg_mem_model.sv */
// word memory standing in for the guard's memory access unit
// assumes one request at a time, held by the guard until memAck
`timescale 1ns/1ps
`default_nettype none
module ssg_mem_model (
	input wire logic core_clk,
	input wire logic [3:0] lag,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [63:0] memAddr,
	input wire logic [63:0] memWdata,
	output logic memAck,
	output logic [63:0] memRdata
);
	logic [63:0] mem [logic [63:0]];
	logic [3:0] cnt = 4'h0;
	initial memAck = 1'b0;
	initial memRdata = 64'h0;
	////////////////////////////////////////
	// read data toggles outside a read answer so a stale word never looks valid
	always @(posedge core_clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck) begin
			cnt <= cnt + 4'h1;
			if (cnt >= lag) begin
				cnt <= 4'h0;
				memAck <= 1'b1;
				if (memWrite)
					mem[memAddr] = memWdata;
				else
					memRdata <= mem.exists(memAddr) ? mem[memAddr] : 64'h0;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench of the shadow stack return guard
// assumes the memory model answers every request of the guard
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ssg_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, regWe = 1'b0, regRe = 1'b0, mgmtAccess = 1'b0;
	logic flowEnable = 1'b1, protectedModeEnable = 1'b1, pagingEnable = 1'b1, virtual8086Flag = 1'b0;
	logic codeLong64 = 1'b1, opValid = 1'b0, opZeroDisp = 1'b0, pageWriteReq = 1'b0, pageShadowAttr = 1'b0;
	logic writeFromTransfer = 1'b0, writeFromMgmt = 1'b0, operandNamesShadowPtr = 1'b0, longModeActive = 1'b1;
	logic [3:0] regAddr = 4'h0, lag = 4'h0;
	logic [63:0] regWdata = 64'h0, opLinearReturn = 64'h0, opCodeSelector = 64'h33;
	logic [1:0] currentPrivilegeLevel = 2'h3, opTargetLevel = 2'h3;
	ssg_op_e opKind = OP_NONE;
	logic [2:0] opStackIndex = 3'h0;
	logic [15:0] opParmBytes = 16'h0;
	logic [63:0] regRdata, memAddr, memWdata, memRdata, shadowTopPointer, v;
	logic opReady, opDone, returnCommit, controlProtectionFault, generalProtectionFault, writeRefused;
	logic operandRefused, memReq, memWrite, memLock, memAck, shadowActive, sawCp, sawGp, sawOk;
	logic [16:0] progSpAdjust;
	int n_errors = 0, num_checks = 0, cyc = 0, writes;
	shadow_stack_return_guard u_shadow_stack_return_guard (.core_clk, .sys_rst, .ce(1'b1), .regAddr,
		.regWdata, .regWe, .regRe, .regRdata, .mgmtAccess, .flowEnable, .protectedModeEnable, .pagingEnable,
		.virtual8086Flag, .longModeActive, .codeLong64, .currentPrivilegeLevel, .opValid, .opKind,
		.opTargetLevel, .opLinearReturn, .opCodeSelector, .opZeroDisp, .opStackIndex, .opParmBytes, .opReady,
		.opDone, .returnCommit, .controlProtectionFault, .generalProtectionFault, .progSpAdjust, .pageWriteReq,
		.pageShadowAttr, .writeFromTransfer, .writeFromMgmt, .writeRefused, .operandNamesShadowPtr,
		.operandRefused, .memReq, .memWrite, .memLock, .memAddr, .memWdata, .memAck, .memRdata, .shadowActive,
		.shadowTopPointer);
	ssg_mem_model u_mem (.core_clk, .lag, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata);
	always #4 core_clk = ~core_clk;
	////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic regWr(input logic [3:0] a, input logic [63:0] d);
		@(posedge core_clk);
		regWe <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWe <= 1'b0;
	endtask
	task automatic regRd(input logic [3:0] a);
		@(posedge core_clk);
		regRe <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRe <= 1'b0;
		#1 v = regRdata;
	endtask
	task automatic lv(input logic [1:0] c);
		@(posedge core_clk);
		currentPrivilegeLevel <= c;
	endtask
	// one operation; collects faults, commit and memory writes until opDone
	task automatic doOp(input ssg_op_e k, input logic [1:0] tl, input logic [63:0] ra, input logic [2:0] ix);
		int i;
		@(posedge core_clk);
		opValid <= 1'b1;
		opKind <= k;
		opTargetLevel <= tl;
		opLinearReturn <= ra;
		opStackIndex <= ix;
		@(posedge core_clk);
		opValid <= 1'b0;
		{sawCp, sawGp, sawOk} = 3'b000;
		writes = 0;
		for (i = 0; i < 100; i++) begin
			#1;
			sawCp |= controlProtectionFault;
			sawGp |= generalProtectionFault;
			sawOk |= returnCommit;
			if ((memAck & memWrite) === 1'b1)
				writes++;
			if (opDone === 1'b1)
				break;
			@(posedge core_clk);
		end
		if (i == 100)
			chk("opDone", 64'h1, 64'h0);
	endtask
	////////////////////////////////////////
	task automatic sc_regs();
		regRd(REG_CAP);
		chk("cap", 64'h1, {63'h0, v[CAP_SS_BIT]});
		chk("ready", 64'h1, {63'h0, opReady});
		regRd(4'hF);
		chk("unmapped", 64'h0, v);
		regWr(REG_PTR, 64'h1000);
		regRd(REG_PTR);
		chk("ptrHidden", 64'h0, v);
		mgmtAccess <= 1'b1;
		operandNamesShadowPtr <= 1'b1;
		regWr(REG_PTR, 64'h2000);
		regRd(REG_PTR);
		chk("ptr", 64'h2000, v);
		chk("operand", 64'h1, {63'h0, operandRefused});
		regWr(REG_SCFG, 64'h1);
	endtask
	task automatic sc_enable();
		logic [3:0] t [5] = '{4'b1110, 4'b0110, 4'b1010, 4'b1100, 4'b1111};
		regWr(REG_UCFG, 64'h1);
		foreach (t[i]) begin
			@(posedge core_clk);
			{flowEnable, protectedModeEnable, pagingEnable, virtual8086Flag} <= t[i];
			@(posedge core_clk);
			#1 chk("active", {63'h0, t[i] == 4'b1110}, {63'h0, shadowActive});
		end
		@(posedge core_clk);
		{flowEnable, protectedModeEnable, pagingEnable, virtual8086Flag} <= 4'b1110;
		regWr(REG_UCFG, 64'h0);
		#1 chk("userOff", 64'h0, {63'h0, shadowActive});
		lv(2'h0);
		#1 chk("superOn", 64'h1, {63'h0, shadowActive});
		regWr(REG_UCFG, 64'h1);
		lv(2'h3);
	endtask
	task automatic sc_near();
		doOp(OP_NEAR_CALL, 2'h3, 64'hA0, 3'h0);
		chk("nearPush", 64'hA0, u_mem.mem[64'h1FF8]);
		chk("sspCall", 64'h1FF8, shadowTopPointer);
		opZeroDisp <= 1'b1;
		doOp(OP_NEAR_CALL, 2'h3, 64'hB0, 3'h0);
		chk("zeroDisp", 64'h0, 64'(writes));
		opZeroDisp <= 1'b0;
		opParmBytes <= 16'h10;
		doOp(OP_NEAR_RET, 2'h3, 64'hA0, 3'h0);
		chk("retOk", 64'h1, {63'h0, sawOk & ~sawCp});
		chk("discard", 64'h18, {47'h0, progSpAdjust});
		chk("sspRet", 64'h2000, shadowTopPointer);
		doOp(OP_NEAR_CALL, 2'h3, 64'hA0, 3'h0);
		doOp(OP_NEAR_RET, 2'h3, 64'hB0, 3'h0);
		chk("retBad", 64'h2, {62'h0, sawCp, sawOk});
		chk("sspKept", 64'h1FF8, shadowTopPointer);
	endtask
	task automatic sc_far();
		regWr(REG_PTR, 64'h2000);
		doOp(OP_FAR_CALL, 2'h3, 64'hC0, 3'h0);
		chk("farAddr", 64'hC0, u_mem.mem[64'h1FF0]);
		chk("farSel", 64'h33, u_mem.mem[64'h1FF8]);
		doOp(OP_FAR_RET, 2'h3, 64'hC0, 3'h0);
		chk("farRet", 64'h1, {63'h0, sawOk & ~sawCp});
		chk("sspFar", 64'h2000, shadowTopPointer);
		regWr(REG_SCFG, 64'h0);
		doOp(OP_FAR_CALL, 2'h0, 64'hC0, 3'h0);
		chk("noSwitch", 64'h0, 64'(writes));
		regWr(REG_SCFG, 64'h1);
	endtask
	task automatic sc_raise();
		lag <= 4'h3;
		u_mem.mem[64'h8000] = 64'h8000;
		u_mem.mem[64'h9000] = 64'h9000;
		regWr(REG_PTR, 64'h2000);
		regWr(REG_PL0, 64'h8000);
		doOp(OP_FAR_CALL, 2'h0, 64'hD0, 3'h0);
		chk("sspRaise", 64'h8000, shadowTopPointer);
		chk("busySet", 64'h8001, u_mem.mem[64'h8000]);
		regRd(REG_PL3);
		chk("userSaved", 64'h2000, v);
		lv(2'h0);
		doOp(OP_FAR_RET, 2'h3, 64'h5, 3'h0);
		chk("retUser", 64'h1, {63'h0, sawOk & ~sawCp});
		chk("sspUser", 64'h2000, shadowTopPointer);
		lv(2'h3);
		doOp(OP_FAR_CALL, 2'h0, 64'hD0, 3'h0);
		chk("busyGp", 64'h8000_0000_0000_8001, {sawGp, u_mem.mem[64'h8000][62:0]});
		regWr(4'h4, 64'h9004);
		doOp(OP_FAR_CALL, 2'h1, 64'hD0, 3'h0);
		chk("alignGp", 64'h1, {63'h0, sawGp});
		regWr(4'h4, 64'h9000);
		lv(2'h2);
		regWr(REG_PTR, 64'h3000);
		doOp(OP_FAR_CALL, 2'h1, 64'hE0, 3'h0);
		chk("oldPtr", 64'h3000, u_mem.mem[64'h8FE8]);
		chk("sspInner", 64'h8FE8, shadowTopPointer);
		lv(2'h1);
		doOp(OP_FAR_RET, 2'h2, 64'hE0, 3'h0);
		chk("retInner", 64'h3000, sawOk ? shadowTopPointer : 64'h0);
	endtask
	task automatic sc_interrupt_shadow_pointer_table();
		lag <= 4'h0;
		u_mem.mem[64'hA010] = 64'hB000;
		u_mem.mem[64'hB000] = 64'hB000;
		u_mem.mem[64'hC000] = 64'hC000;
		regWr(REG_INTERRUPT_SHADOW_POINTER_TABLE, 64'hA000);
		regWr(REG_PL0, 64'hC000);
		lv(2'h3);
		doOp(OP_INTR, 2'h0, 64'hF0, 3'h2);
		chk("interrupt_shadow_pointer_table", 64'hB000, shadowTopPointer);
		lv(2'h3);
		doOp(OP_INTR, 2'h0, 64'hF0, 3'h0);
		chk("perLevel", 64'hC000, shadowTopPointer);
		u_mem.mem[64'hD000] = 64'hD000;
		regWr(REG_PL0, 64'hD000);
		longModeActive <= 1'b0;
		doOp(OP_INTR, 2'h0, 64'hF0, 3'h2);
		chk("legacyIdx", 64'hD000, shadowTopPointer);
	endtask
	task automatic sc_misc();
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			{pageShadowAttr, writeFromTransfer, writeFromMgmt} <= i[2:0];
			pageWriteReq <= 1'b1;
			@(posedge core_clk);
			#1 chk("refused", {63'h0, i == 4}, {63'h0, writeRefused});
		end
		lv(2'h3);
		codeLong64 <= 1'b0;
		regWr(REG_PTR, 64'h1_0000_2000);
		doOp(OP_NEAR_CALL, 2'h3, 64'hA0, 3'h0);
		chk("legacy", 64'h1FF8, shadowTopPointer);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		sc_regs();
		sc_enable();
		sc_near();
		sc_far();
		sc_raise();
		sc_interrupt_shadow_pointer_table();
		sc_misc();
		wrap_up();
	end
endmodule
`default_nettype wire
